// >>> logic/sdfp_port.sv
// Purpose: Card-side SDIO function port: command decode, write data path.
// Assumes: Bus clock is sampled by clock_in; bus clock well below core.
// Notes: Only CMD52/CMD53 decode; responses are left to the core logic.
//
// Summary of operation
// - Default speed to 25 MHz, one or four data lines.
// - High-speed mode with host clock up to 50 MHz.
// - SDR12 and SDR25 clock grades; SDR50 and SDR104 are beyond the 100 MHz sampler.
// - DDR mode: data on both clock edges, clock up to 50 MHz.
// - Works with version 2.0 hosts; newer modes stay optional.
// - Function 0 transfers carry at most 32 bytes.
// - Function 1 reaches on-chip address space, at most 64 bytes.
// - Function 2 moves WLAN packets to DMA, at most 512 bytes.
// - Second data line: data bit 1 plus interrupt; interrupt in either width.
// - Third data line: data bit 2 plus read wait; fourth unused 1-bit.
// - Interrupt may be routed to a GPIO pin instead.
// - Internal logic may force the gated clock enables.
// - Port active only when straps sampled at reset select it.
`timescale 1ns/1ns
module sdfp_port (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [1:0] strap_in,
  input wire logic sd_clk_in,
  input wire logic sd_cmd_in,
  input wire logic [3:0] sd_dat_in,
  output logic [3:0] sd_dat_out,
  output logic [3:0] sd_dat_oe_out,
  input wire logic wide_bus_in,
  input wire logic ddr_mode_in,
  input wire logic irq_req_in,
  input wire logic irq_to_gpio_in,
  output logic gpio_irq_out,
  input wire logic read_wait_in,
  input wire logic [2:0] clk_force_in,
  input wire logic [2:0] clk_force_val_in,
  output logic [2:0] clk_gate_out,
  output logic port_active_out,
  output logic cmd_valid_out,
  output logic cmd_write_out,
  output logic cmd_block_out,
  output logic cmd_extended_out,
  output logic [2:0] cmd_func_out,
  output logic [16:0] cmd_addr_out,
  output logic [8:0] cmd_count_out,
  output logic cmd_reject_out,
  output logic dma_valid_out,
  input wire logic dma_ready_in,
  output logic [7:0] dma_data_out,
  output logic data_stall_out
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    // Strap capture, taken once per reset
    logic strap_taken;
    logic active;
    // Three-stage samplers for every bus pin
    logic [2:0] clk_s;
    logic [2:0] cmd_s;
    logic [3:0][2:0] dat_s;
    // Command frame assembly
    logic [47:0] shreg;
    logic [5:0] bitcnt;
    logic in_frame;
    // Decoded command: valid pulses, fields held until the next one
    logic cmd_valid;
    logic cmd_write;
    logic cmd_block;
    logic cmd_ext;
    logic [2:0] cmd_func;
    logic [16:0] cmd_addr;
    logic [8:0] cmd_count;
    logic cmd_reject;
    // Write data assembly towards the buffer
    logic wr_phase;
    logic [9:0] wr_left;
    logic [7:0] byte_sh;
    logic [3:0] nib_cnt;
    logic byte_valid;
    logic [7:0] byte_data;
    // Line drive, interrupt pin and clock gates
    logic [3:0] dat_o;
    logic [3:0] dat_oe;
    logic gpio_irq;
    logic [2:0] gate;
  } sdfp_port_s;
  sdfp_port_s st;
  sdfp_port_s next_st;

  logic fifo_ready;
  logic clk_rise;
  logic clk_fall;
  logic cmd_lvl;
  logic [3:0] dat_lvl;
  logic sample_edge;
  logic [9:0] fn_limit;
  logic [9:0] req_bytes;
  logic [2:0] fn;

  // ----------------------------------------------------------------
  // Pin sampling: an edge counts when stages two and three differ
  // ----------------------------------------------------------------
  // Edges are taken between stages two and three, never from stage one
  assign clk_rise = st.clk_s[1] && !st.clk_s[2];
  assign clk_fall = !st.clk_s[1] && st.clk_s[2];
  assign cmd_lvl = st.cmd_s[2];
  generate
    for (genvar i = 0; i < 4; i++) begin : g_dat
      assign dat_lvl[i] = st.dat_s[i][2];
    end
  endgenerate
  // DDR takes data on both edges, SDR modes on the rising edge only
  assign sample_edge = clk_rise || (ddr_mode_in && clk_fall);

  // ----------------------------------------------------------------
  // Per-function limit lookup
  // ----------------------------------------------------------------
  // Argument fields sit eight bits up, above the check byte
  localparam int ARG_FN_MSB_POS = sdfp_pkg::ARG_FN_MSB + 8;
  localparam int ARG_FN_LSB_POS = sdfp_pkg::ARG_FN_LSB + 8;
  assign fn = st.shreg[ARG_FN_MSB_POS:ARG_FN_LSB_POS];
  // Limit of the addressed function; absent functions get zero
  always_comb begin
    fn_limit = '0;
    unique case (fn)
      3'h0: fn_limit = sdfp_pkg::FN0_MAX_BYTES;
      3'h1: fn_limit = sdfp_pkg::FN1_MAX_BYTES;
      3'h2: fn_limit = sdfp_pkg::FN2_MAX_BYTES;
      default: fn_limit = '0;
    endcase
  end
  // Byte count of zero means the full 512 bytes
  assign req_bytes = (st.shreg[16:8] == 9'h000) ? 10'h200 :
                     {1'b0, st.shreg[16:8]};

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.clk_s = {st.clk_s[1:0], sd_clk_in};
    next_st.cmd_s = {st.cmd_s[1:0], sd_cmd_in};
    for (int i = 0; i < 4; i++) begin
      next_st.dat_s[i] = {st.dat_s[i][1:0], sd_dat_in[i]};
    end
    // Pulses last one cycle unless set again below
    next_st.cmd_valid = 1'b0;
    next_st.byte_valid = 1'b0;

    // --------------------------------------------------------------
    // Strap capture
    // --------------------------------------------------------------
    // Straps caught once, on the first edge after reset release
    // Later strap changes are ignored until the next reset
    if (!st.strap_taken) begin
      next_st.strap_taken = 1'b1;
      next_st.active = (strap_in == sdfp_pkg::STRAP_SDIO);
    end

    // --------------------------------------------------------------
    // Command frame assembly
    // --------------------------------------------------------------
    // Command line: start bit opens a 48-bit frame
    // No check byte test: a corrupt frame decodes as whatever it holds
    if (st.active && clk_rise) begin
      if (!st.in_frame) begin
        if (!cmd_lvl) begin
          next_st.in_frame = 1'b1;
          next_st.bitcnt = 6'h01;
          next_st.shreg = {47'h0, cmd_lvl};
        end
      end else begin
        next_st.shreg = {st.shreg[46:0], cmd_lvl};
        next_st.bitcnt = st.bitcnt + 6'h01;
        if (st.bitcnt == 6'(sdfp_pkg::CMD_BITS - 1)) begin
          next_st.in_frame = 1'b0;
        end
      end
    end

    // --------------------------------------------------------------
    // Command decode
    // --------------------------------------------------------------
    // Frame complete: decode on the cycle after the last bit
    // Fields are kept on a refusal so the core can see what was asked
    if (st.active && !st.in_frame && st.bitcnt == 6'(sdfp_pkg::CMD_BITS)) begin
      next_st.bitcnt = '0;
      if (st.shreg[45:40] == sdfp_pkg::CMD_IO_DIRECT ||
          st.shreg[45:40] == sdfp_pkg::CMD_IO_EXTENDED) begin
        next_st.cmd_valid = 1'b1;
        next_st.cmd_ext = st.shreg[45:40] == sdfp_pkg::CMD_IO_EXTENDED;
        next_st.cmd_write = st.shreg[sdfp_pkg::ARG_RW_BIT + 8];
        next_st.cmd_func = fn;
        next_st.cmd_block = next_st.cmd_ext &&
                            st.shreg[sdfp_pkg::ARG_BLK_BIT + 8];
        next_st.cmd_addr = st.shreg[33:17];
        next_st.cmd_count = st.shreg[16:8];
        // Unknown function or oversize transfer is refused
        next_st.cmd_reject = fn >= sdfp_pkg::FN_COUNT ||
                             (next_st.cmd_ext && req_bytes > fn_limit);
        if (next_st.cmd_ext && next_st.cmd_write && !next_st.cmd_reject) begin
          next_st.wr_phase = 1'b1;
          next_st.wr_left = req_bytes;
          next_st.nib_cnt = '0;
        end
      end
    end

    // --------------------------------------------------------------
    // Write data path
    // --------------------------------------------------------------
    // Write data: nibbles in 4-bit mode, bits in 1-bit mode
    // A full buffer skips bus edges; the host must pause on stall
    if (st.wr_phase && sample_edge && fifo_ready) begin
      if (wide_bus_in) begin
        next_st.byte_sh = {st.byte_sh[3:0], dat_lvl};
        next_st.nib_cnt = st.nib_cnt + 4'h4;
      end else begin
        next_st.byte_sh = {st.byte_sh[6:0], dat_lvl[0]};
        next_st.nib_cnt = st.nib_cnt + 4'h1;
      end
      if (next_st.nib_cnt == 4'h8) begin
        next_st.nib_cnt = '0;
        next_st.byte_valid = 1'b1;
        next_st.byte_data = next_st.byte_sh;
        next_st.wr_left = st.wr_left - 10'h001;
        if (st.wr_left == 10'h001) begin
          next_st.wr_phase = 1'b0;
        end
      end
    end

    // --------------------------------------------------------------
    // Line drive and interrupt routing
    // --------------------------------------------------------------
    // Interrupt on line 1 outside data, or on a GPIO when routed
    // Lines are only ever pulled low; the pull-ups give the high level
    next_st.gpio_irq = st.active && irq_to_gpio_in && irq_req_in;
    next_st.dat_o = 4'h0;
    next_st.dat_oe = 4'h0;
    if (st.active && irq_req_in && !irq_to_gpio_in && !st.wr_phase) begin
      next_st.dat_oe[1] = 1'b1;
    end
    // Read wait holds line 2 low; host sees it in either width
    if (st.active && read_wait_in && !st.wr_phase) begin
      next_st.dat_oe[2] = 1'b1;
    end

    // --------------------------------------------------------------
    // Clock gates
    // --------------------------------------------------------------
    // Gated clocks follow activity unless forced from inside
    // Forcing a gate off mid-transfer is the core's own risk
    for (int g = 0; g < sdfp_pkg::GATE_COUNT; g++) begin
      next_st.gate[g] = clk_force_in[g] ? clk_force_val_in[g] :
                        (st.active && (st.in_frame || st.wr_phase));
    end
  end

  // State register; reset clears straps so they are caught again
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Data buffer towards the function DMA
  // ----------------------------------------------------------------
  sdfp_fifo #(
    .WIDTH(sdfp_pkg::FIFO_WIDTH),
    .DEPTH(sdfp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .wr_valid_in(st.byte_valid),
    .wr_ready_out(fifo_ready),
    .wr_data_in(st.byte_data),
    .rd_valid_out(dma_valid_out),
    .rd_ready_in(dma_ready_in),
    .rd_data_out(dma_data_out)
  );

  // Outputs straight from state
  assign sd_dat_out = st.dat_o;
  assign sd_dat_oe_out = st.dat_oe;
  assign gpio_irq_out = st.gpio_irq;
  assign clk_gate_out = st.gate;
  assign port_active_out = st.active;
  assign cmd_valid_out = st.cmd_valid;
  assign cmd_write_out = st.cmd_write;
  assign cmd_block_out = st.cmd_block;
  assign cmd_extended_out = st.cmd_ext;
  assign cmd_func_out = st.cmd_func;
  assign cmd_addr_out = st.cmd_addr;
  assign cmd_count_out = st.cmd_count;
  assign cmd_reject_out = st.cmd_reject;
  // Stall shows the host-side data path is held by a full buffer
  assign data_stall_out = st.wr_phase && !fifo_ready;
endmodule

// >>> logic/sdfp_pkg.sv
// Purpose: Shared constants for the SDIO card function port.
// Assumes: 100 MHz core clock; bus clock sampled as an ordinary input.
// Notes: Command frame layout follows the public SDIO CMD52/CMD53 format.
package sdfp_pkg;
  // ----------------------------------------------------------------
  // Bus timing
  // ----------------------------------------------------------------
  localparam int CORE_MHZ = 100;
  localparam int DS_MAX_MHZ = 25;
  localparam int HS_MAX_MHZ = 50;
  localparam int SDR104_MAX_MHZ = 208;
  localparam int DDR50_MAX_MHZ = 50;
  // ----------------------------------------------------------------
  // Command frame
  // ----------------------------------------------------------------
  localparam int CMD_BITS = 48;
  localparam logic [5:0] CMD_IO_DIRECT = 6'h34;
  localparam logic [5:0] CMD_IO_EXTENDED = 6'h35;
  localparam int ARG_RW_BIT = 31;
  localparam int ARG_FN_MSB = 30;
  localparam int ARG_FN_LSB = 28;
  localparam int ARG_BLK_BIT = 27;
  localparam int ARG_ADDR_MSB = 25;
  localparam int ARG_ADDR_LSB = 9;
  localparam int ARG_CNT_MSB = 8;
  localparam int ARG_CNT_LSB = 0;
  // ----------------------------------------------------------------
  // Per-function block limits
  // ----------------------------------------------------------------
  localparam logic [9:0] FN0_MAX_BYTES = 10'h020;
  localparam logic [9:0] FN1_MAX_BYTES = 10'h040;
  localparam logic [9:0] FN2_MAX_BYTES = 10'h200;
  localparam logic [2:0] FN_COUNT = 3'h3;
  // ----------------------------------------------------------------
  // Straps and data path
  // ----------------------------------------------------------------
  localparam logic [1:0] STRAP_SDIO = 2'h1;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int GATE_COUNT = 3;

  typedef enum logic [1:0] {
    SDFP_WIDTH1,
    SDFP_WIDTH4
  } sdfp_width_e;
endpackage

// >>> logic/sdfp_fifo.sv
// Purpose: Byte FIFO between the card data line and the function DMA.
// Assumes: Single clock; write and read may occur in one cycle.
// Notes: Full and empty are exact, derived from an occupancy count.
`timescale 1ns/1ns
module sdfp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
  } sdfp_fifo_s;
  sdfp_fifo_s st;
  sdfp_fifo_s next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign wr_ready_out = (st.count != (AW+1)'(DEPTH));
  assign rd_valid_out = (st.count != '0);
  assign push = wr_valid_in && wr_ready_out;
  assign pop = rd_valid_out && rd_ready_in;
  assign rd_data_out = mem[st.rptr];

  // Storage has no reset; contents are qualified by the count
  always_ff @(posedge clock_in) begin
    if (push) begin
      mem[st.wptr] <= wr_data_in;
    end
  end

  // Pointer and occupancy update
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wptr = st.wptr + 1'b1;
    end
    if (pop) begin
      next_st.rptr = st.rptr + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// >>> testbench/sdfp_port_chk.sv
// Purpose: Port-level assertions for the SDIO card function port.
// Assumes: Straps and mode inputs are static levels around commands.
// Notes: Bound to every sdfp_port instance at the foot of this file.
`timescale 1ns/1ns
module sdfp_port_chk (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic irq_req_in,
  input wire logic irq_to_gpio_in,
  input wire logic dma_ready_in,
  input wire logic [2:0] clk_force_in,
  input wire logic [2:0] clk_force_val_in,
  input wire logic [3:0] sd_dat_out,
  input wire logic [3:0] sd_dat_oe_out,
  input wire logic gpio_irq_out,
  input wire logic [2:0] clk_gate_out,
  input wire logic port_active_out,
  input wire logic cmd_valid_out,
  input wire logic cmd_extended_out,
  input wire logic [2:0] cmd_func_out,
  input wire logic [8:0] cmd_count_out,
  input wire logic cmd_reject_out,
  input wire logic dma_valid_out,
  input wire logic [7:0] dma_data_out,
  input wire logic data_stall_out
);
  // ------
  // Byte count of a decoded command, zero meaning 512
  // ------
  logic [9:0] n_bytes;
  logic [9:0] lim;
  assign n_bytes = (cmd_count_out == 9'h000) ? 10'h200 : {1'h0, cmd_count_out};
  assign lim = (cmd_func_out == 3'h0) ? sdfp_pkg::FN0_MAX_BYTES :
    (cmd_func_out == 3'h1) ? sdfp_pkg::FN1_MAX_BYTES : sdfp_pkg::FN2_MAX_BYTES;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  AST_LIMIT: assert property (
    cmd_valid_out && cmd_extended_out && cmd_func_out < 3'h3
    |-> cmd_reject_out == (n_bytes > lim)) else $error("limit verdict wrong");
  AST_BAD_FN: assert property (
    cmd_valid_out && cmd_func_out >= 3'h3 |-> cmd_reject_out)
    else $error("missing function refused");
  AST_DIRECT: assert property (
    cmd_valid_out && !cmd_extended_out && cmd_func_out < 3'h3
    |-> !cmd_reject_out) else $error("direct command refused");
  AST_PULSE: assert property (
    cmd_valid_out |=> !cmd_valid_out) else $error("command pulse too long");
  AST_IDLE: assert property (
    !port_active_out |-> !cmd_valid_out && !dma_valid_out)
    else $error("inactive port produced traffic");
  AST_DRIVE_LOW: assert property (
    sd_dat_out == 4'h0 && sd_dat_oe_out[0] == 1'h0 && sd_dat_oe_out[3] == 1'h0)
    else $error("card drove a data line wrongly");
  AST_GPIO: assert property (
    port_active_out && $past(port_active_out && irq_to_gpio_in)
    |-> gpio_irq_out == $past(irq_req_in) && !sd_dat_oe_out[1])
    else $error("interrupt not on gpio");
  AST_FORCE: assert property (
    ((clk_gate_out ^ $past(clk_force_val_in)) & $past(clk_force_in)) == 3'h0)
    else $error("forced gate wrong");
  AST_DMA_HOLD: assert property (
    dma_valid_out && !dma_ready_in |=> dma_valid_out && $stable(dma_data_out))
    else $error("dma word dropped while stalled");
  AST_STALL: assert property (
    data_stall_out |-> dma_valid_out) else $error("stall with empty buffer");
endmodule
bind sdfp_port sdfp_port_chk u_chk (.clock_in, .reset_n_in, .irq_req_in,
  .irq_to_gpio_in, .dma_ready_in, .clk_force_in, .clk_force_val_in,
  .sd_dat_out, .sd_dat_oe_out, .gpio_irq_out, .clk_gate_out,
  .port_active_out, .cmd_valid_out, .cmd_extended_out, .cmd_func_out,
  .cmd_count_out, .cmd_reject_out, .dma_valid_out, .dma_data_out,
  .data_stall_out);

// >>> testbench/sdfp_host.sv
// Purpose: Behavioural SDIO host: bus clock, command and write data.
// Assumes: Tasks are entered just after a core clock rising edge.
// Notes: Clock rests low and all lines are released between frames.
`timescale 1ns/1ns
module sdfp_host (
  input wire logic clock_in,
  output logic sd_clk_out,
  output logic sd_cmd_out,
  output logic [3:0] dat_out,
  output logic [3:0] dat_oe_out
);
  // ------
  // Bus cycles
  // ------
  localparam int HALF = 8; // 160 ns period, below 25 MHz
  initial begin
    sd_clk_out = 1'h0;
    sd_cmd_out = 1'h1;
    dat_out = 4'h0;
    dat_oe_out = 4'h0;
  end
  // Lines change while low so the card sees them stable at the rise
  task automatic tick(input logic c, input logic [3:0] d, input logic [3:0] oe);
    sd_clk_out <= 1'h0;
    sd_cmd_out <= c;
    dat_out <= d;
    dat_oe_out <= oe;
    repeat (HALF) @(posedge clock_in);
    sd_clk_out <= 1'h1;
    repeat (HALF) @(posedge clock_in);
  endtask
  // Frame MSB first; CRC left zero, limits broken only on request
  task automatic send_cmd(input logic [5:0] idx, input logic [31:0] arg);
    logic [47:0] f;
    f = {2'h1, idx, arg, 8'h01};
    for (int i = 47; i >= 0; i--) tick(f[i], 4'h0, 4'h0);
  endtask
  // Nibbles on DAT3..0, or bits on DAT0 with DAT3 left alone
  task automatic send_byte(input logic [7:0] b, input logic wide);
    if (wide) begin
      tick(1'h1, b[7:4], 4'hf);
      tick(1'h1, b[3:0], 4'hf);
    end else begin
      for (int i = 7; i >= 0; i--) tick(1'h1, {3'h0, b[i]}, 4'h1);
    end
  endtask
  // Double rate byte: high nibble at the rise, low nibble at the fall
  task automatic send_ddr(input logic [7:0] b);
    sd_clk_out <= 1'h0;
    dat_out <= b[7:4];
    dat_oe_out <= 4'hf;
    repeat (HALF) @(posedge clock_in);
    sd_clk_out <= 1'h1;
    repeat (HALF / 2) @(posedge clock_in);
    dat_out <= b[3:0];
    repeat (HALF / 2) @(posedge clock_in);
    sd_clk_out <= 1'h0;
    repeat (HALF) @(posedge clock_in);
  endtask
  // Clock stands still; released lines fall back to the pull-ups
  task automatic rest();
    sd_clk_out <= 1'h0;
    sd_cmd_out <= 1'h1;
    dat_oe_out <= 4'h0;
    repeat (HALF) @(posedge clock_in);
  endtask
endmodule

// >>> testbench/sdfp_port_tb_top.sv
// Purpose: Self-checking bench for the SDIO card function port.
// Assumes: Host model supplies the bus; core clock 100 MHz.
// Notes: Data lines resolve as pulled-up open-drain wires.
`timescale 1ns/1ns
module sdfp_port_tb_top;
  logic clock_in, reset_n, sd_clk, sd_cmd, wide, ddr, irq_req, irq_gpio;
  logic gpio_irq, rd_wait, active, cv, cw, cb, ce, crj, dv, dr, stall;
  logic [1:0] strap;
  logic [3:0] h_dat, h_oe, d_dat, d_oe, dat_wire;
  logic [2:0] frc, frc_val, gate, cf;
  logic [16:0] ca;
  logic [8:0] cc;
  logic [7:0] dd;
  logic [7:0] rxq[$];
  int n_fail = 0;
  int check_count = 0;
  int n_cmd = 0;
  // ------
  // Wiring and collection
  // ------
  assign dat_wire = ~((h_oe & ~h_dat) | (d_oe & ~d_dat));
  sdfp_port DUT (.clock_in(clock_in), .reset_n_in(reset_n), .strap_in(strap),
    .sd_clk_in(sd_clk), .sd_cmd_in(sd_cmd), .sd_dat_in(dat_wire),
    .sd_dat_out(d_dat), .sd_dat_oe_out(d_oe), .wide_bus_in(wide),
    .ddr_mode_in(ddr), .irq_req_in(irq_req), .irq_to_gpio_in(irq_gpio),
    .gpio_irq_out(gpio_irq), .read_wait_in(rd_wait), .clk_force_in(frc),
    .clk_force_val_in(frc_val), .clk_gate_out(gate), .port_active_out(active),
    .cmd_valid_out(cv), .cmd_write_out(cw), .cmd_block_out(cb),
    .cmd_extended_out(ce), .cmd_func_out(cf), .cmd_addr_out(ca),
    .cmd_count_out(cc), .cmd_reject_out(crj), .dma_valid_out(dv),
    .dma_ready_in(dr), .dma_data_out(dd), .data_stall_out(stall));
  sdfp_host host (.clock_in(clock_in), .sd_clk_out(sd_clk),
    .sd_cmd_out(sd_cmd), .dat_out(h_dat), .dat_oe_out(h_oe));
  initial begin
    clock_in = 1'h0;
    forever #5 clock_in = ~clock_in;
  end
  // Drained bytes and command pulses, seen like a flop would
  always @(posedge clock_in) begin
    if (dv && dr) rxq.push_back(dd);
    if (cv) n_cmd++;
  end
  function automatic logic [7:0] pat(input int i);
    return 8'(i * 37 + 28);
  endfunction
  task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic do_reset(input logic [1:0] s);
    @(posedge clock_in);
    strap <= s;
    reset_n <= 1'h0;
    repeat (6) @(negedge clock_in);
    check("active_in_reset", active, 0);
    @(posedge clock_in);
    reset_n <= 1'h1;
    repeat (3) @(negedge clock_in);
    check("active", active, s == 2'h1);
  endtask
  // One command frame, then its pulse, fields and verdict
  task automatic cmd(input logic [5:0] idx, input logic wr, input logic [2:0] fn,
      input logic blk, input logic [16:0] a, input logic [8:0] c,
      input logic rej);
    int n0;
    n0 = n_cmd;
    @(posedge clock_in);
    host.send_cmd(idx, {wr, fn, blk, 1'h0, a, c});
    host.rest();
    @(negedge clock_in);
    check("cmd_pulses", n_cmd, n0 + 1);
    check("cmd_fields", {cw, cb, ce, cf, ca, cc},
      {wr, blk, idx == sdfp_pkg::CMD_IO_EXTENDED, fn, a, c});
    check("cmd_reject", crj, rej);
  endtask
  // Limits at each edge and past those of functions 0 and 1, missing function, non-IO command
  task automatic t_limits();
    logic [15:0] tb_e [8];
    int n0;
    tb_e = '{16'h0040, 16'h0043, 16'h0880, 16'h0883, 16'h1000, 16'h0401,
      16'h1809, 16'h0c80};
    cmd(sdfp_pkg::CMD_IO_DIRECT, 1'h1, 3'h1, 1'h0, 17'h1abcd, 9'h0a5, 1'h0);
    cmd(sdfp_pkg::CMD_IO_DIRECT, 1'h0, 3'h5, 1'h0, 17'h00003, 9'h000, 1'h1);
    for (int i = 0; i < 8; i++) cmd(sdfp_pkg::CMD_IO_EXTENDED, 1'h0,
      tb_e[i][13:11], tb_e[i][10], 17'(i), tb_e[i][9:1], tb_e[i][0]);
    n0 = n_cmd;
    @(posedge clock_in);
    host.send_cmd(6'h11, 32'h0000_0000);
    host.rest();
    @(negedge clock_in);
    check("non_io", n_cmd, n0);
  endtask
  // Write burst to function 2; hold > 0 stalls the drain until full
  task automatic t_data(input logic wm, input int n, input int hold,
      input logic dm);
    @(posedge clock_in);
    wide <= wm;
    dr <= (hold == 0);
    rxq.delete();
    cmd(sdfp_pkg::CMD_IO_EXTENDED, 1'h1, 3'h2, 1'h0, 17'h00040, 9'(n), 1'h0);
    // Double rate only after the frame's closing fall has passed
    @(posedge clock_in);
    ddr <= dm;
    for (int i = 0; i < n; i++) begin
      @(posedge clock_in);
      if (dm) host.send_ddr(pat(i));
      else host.send_byte(pat(i), wm);
      if (i + 1 == hold) begin
        @(negedge clock_in);
        check("stall_full", {stall, dv, 8'(rxq.size())}, 10'h300);
        @(posedge clock_in);
        host.rest();
        dr <= 1'h1;
        repeat (40) @(negedge clock_in);
        check("drained", {stall, 8'(rxq.size())}, {1'h0, 8'(hold)});
      end
    end
    @(posedge clock_in);
    host.rest();
    for (int k = 0; k < 100 && rxq.size() < n; k++) @(negedge clock_in);
    check("rx_count", rxq.size(), n);
    for (int i = 0; i < n; i++) check("rx_byte", rxq[i], pat(i));
    ddr <= 1'h0;
  endtask
  // Interrupt pin in both widths; read wait and gpio routing in 1-bit width only
  task automatic t_pins();
    @(posedge clock_in);
    wide <= 1'h0;
    irq_req <= 1'h1;
    repeat (3) @(negedge clock_in);
    check("irq_dat1", {d_oe[1], d_dat[1], gpio_irq}, 3'h4);
    @(posedge clock_in);
    irq_gpio <= 1'h1;
    rd_wait <= 1'h1;
    repeat (3) @(negedge clock_in);
    check("irq_gpio", {d_oe[2:1], gpio_irq, d_oe[3]}, 4'ha);
    @(posedge clock_in);
    irq_gpio <= 1'h0;
    rd_wait <= 1'h0;
    wide <= 1'h1;
    repeat (3) @(negedge clock_in);
    check("irq_wide", {d_oe, gpio_irq}, 5'h04);
    @(posedge clock_in);
    irq_req <= 1'h0;
  endtask
  // Forced gate values, all bits and then a single bit
  task automatic t_force();
    @(posedge clock_in);
    frc <= 3'h7;
    frc_val <= 3'h5;
    repeat (2) @(negedge clock_in);
    check("gate_force", gate, 3'h5);
    @(posedge clock_in);
    frc <= 3'h2;
    frc_val <= 3'h0;
    repeat (2) @(negedge clock_in);
    check("gate_bit1", gate[1], 1'h0);
    @(posedge clock_in);
    frc <= 3'h0;
    repeat (2) @(negedge clock_in);
    check("gate_idle", gate, 3'h0);
  endtask
  // Wrong strap: port stays inactive, then a second reset restores it
  task automatic t_strap();
    int n0;
    do_reset(2'h2);
    n0 = n_cmd;
    @(posedge clock_in);
    host.send_cmd(sdfp_pkg::CMD_IO_DIRECT, 32'h9000_0000);
    host.rest();
    @(negedge clock_in);
    check("inactive_cmd", n_cmd, n0);
    do_reset(2'h1);
  endtask
  initial begin
    reset_n = 1'h0;
    strap = 2'h1;
    {wide, ddr, irq_req, irq_gpio, rd_wait, frc, frc_val, dr} = 12'h001;
    do_reset(2'h1);
    t_limits();
    t_data(1'h1, 5, 0, 1'h0);
    t_data(1'h0, 3, 0, 1'h0);
    t_data(1'h1, 40, 32, 1'h0);
    t_data(1'h1, 4, 0, 1'h1);
    t_pins();
    t_force();
    t_strap();
    final_report();
  end
  // Watchdog well past the expected 15k cycles of traffic
  initial begin
    #1000000;
    n_fail++;
    final_report();
  end
endmodule
